// file: itp_consts.svh
// Constants of the interval timer pair: register offsets, field positions,
// reset values and response codes.
// Assumes inclusion by bare name from the timer, its checker and the bench.
`ifndef ITP_CONSTS_SVH
`define ITP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ITP_OFS_LONG_CTRL   8'h00
`define ITP_OFS_BYTE_CTRL   8'h04
`define ITP_OFS_BYTE_DIV    8'h08
`define ITP_OFS_BYTE_CMP    8'h0C
`define ITP_OFS_IRQ_STATUS  8'h10
`define ITP_OFS_IRQ_MASK    8'h14
`define ITP_OFS_COUNT       8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ITP_LONG_RUN_BIT    15
`define ITP_LONG_CMP_MSB    11
`define ITP_CASCADE_BIT     7
`define ITP_GATE_BIT        4
`define ITP_CH1_GO_BIT      1
`define ITP_CH0_GO_BIT      0
`define ITP_CH1_DIV_LSB     4
`define ITP_CH0_DIV_LSB     0
`define ITP_IRQ_LONG_BIT    0
`define ITP_IRQ_CH0_BIT     1
`define ITP_IRQ_CH1_BIT     2
`define ITP_COUNT_LONG_LSB  16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ITP_RST_LONG_CMP    12'hFFF
`define ITP_RST_BYTE_CMP    16'hFFFF
`define ITP_RST_DIV         3'h0
`define ITP_RST_MASK        3'h7

// ----------------------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------------------
`define ITP_RESP_OKAY       2'h0
`define ITP_RESP_SLVERR     2'h2

`endif

// file: itp_pkg.sv
// Types shared by the interval timer pair.
// Assumes itp_consts.svh is reachable on the include path.
package itp_pkg;

  // Sticky interrupt status and its mask share this layout
  typedef logic [2:0]  itp_irq_t;
  // Prescaler select: divide by two to the power of this value
  typedef logic [2:0]  itp_div_t;
  // Compare value of the byte timer, both channels side by side
  typedef logic [15:0] itp_cmp_t;

endpackage

// file: itp_counter.sv
// One periodic counter: counts ticks from zero up to its compare value,
// then pulses match and restarts from zero.
// Assumes tick is a one-cycle pulse on aclk and cmp is steady while running.
`timescale 1ns/1ns
module itp_counter #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] cmp,
  // State
  output logic      [W-1:0] count_q,
  output logic              match_q
);

  initial
  begin
    if (W < 1 || W > 16)
      $error("itp_counter: W must lie between 1 and 16");
  end

  // --------------------------------------------------------------------------
  // Count and wrap
  // --------------------------------------------------------------------------
  // Stopping clears the count so the next start measures a whole period
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      count_q <= '0;
    else if (tick && count_q == cmp)
      count_q <= '0;
    else if (tick)
      count_q <= count_q + W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      match_q <= 1'b0;
    else
      match_q <= run && tick && (count_q == cmp);
  end

endmodule

// file: itp_timer.sv
// Interval timer pair: a 12-bit periodic timer and a two-channel byte timer
// with prescaler and 16-bit cascade, behind an AXI4-Lite register slave.
// Assumes low_speed_clock is a slow pin clock, well under half of aclk.
//
// Notes on behaviour
// RULE1: long timer flag sets on interval, stays set
// RULE2: run low clears count; high starts counting
// RULE3: interval every compare plus one count clocks
// RULE4: software never programs a zero long compare
// RULE5: cascade bit joins channels into 16 bits
// RULE6: clock gate bit low freezes byte timer
// RULE7: channel zero go bit starts, stops counting
// RULE8: divide select gives low clock over 2^n
// RULE9: mask one blocks interrupt; flag still sets (code masks irq only; long_timer_interval_irq pulses unmasked)
// RULE10: cascade matches 16-bit compare, then restarts
`timescale 1ns/1ns
`include "itp_consts.svh"
module itp_timer #(
  parameter int ADDR_W = 8,
  parameter int LONG_W = 12,
  parameter int BYTE_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Count clock source
  input  wire logic              low_speed_clock,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupts
  output logic                   long_timer_interval_irq,
  output logic                   irq
);

  initial
  begin
    if (ADDR_W < 5 || ADDR_W > 8)
      $error("itp_timer: ADDR_W must lie between 5 and 8");
    if (LONG_W != 12 || BYTE_W != 8)
      $error("itp_timer: register layout fixes LONG_W=12, BYTE_W=8");
  end

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  logic                  long_timer_run_q;
  logic [LONG_W-1:0]     long_timer_compare_q;
  logic                  cascade_mode_select_q;
  logic                  byte_timer_clock_gate_q;
  logic                  byte_timer_ch0_go_q;
  logic                  byte_timer_ch1_go_q;
  itp_pkg::itp_div_t     byte_timer_ch0_divsel_q;
  itp_pkg::itp_div_t     byte_timer_ch1_divsel_q;
  itp_pkg::itp_cmp_t     byte_timer_compare_q;
  itp_pkg::itp_irq_t     irq_status_q;
  itp_pkg::itp_irq_t     irq_status_d;
  itp_pkg::itp_irq_t     irq_mask_high_1_q;
  itp_pkg::itp_irq_t     irq_set;
  itp_pkg::itp_irq_t     irq_clr;

  logic                  lsc_meta_q;
  logic                  lsc_sync_q;
  logic                  lsc_prev_q;
  logic                  lsc_tick;
  logic [6:0]            pre_q;
  logic                  tick_ch0;
  logic                  tick_ch1;

  logic [LONG_W-1:0]     long_count;
  logic                  long_match;
  logic [BYTE_W-1:0]     ch0_count;
  logic [BYTE_W-1:0]     ch1_count;
  logic [2*BYTE_W-1:0]   casc_count;
  logic                  ch0_match;
  logic                  ch1_match;
  logic                  casc_match;

  logic                  aw_held_q;
  logic [ADDR_W-1:0]     aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  wr_fire;
  logic [31:0]           wr_mask;
  logic [31:0]           long_img;
  logic [31:0]           bcmp_img;
  logic                  wr_hit;
  logic                  rd_fire;
  logic [31:0]           rd_word;
  logic                  rd_hit;

  // --------------------------------------------------------------------------
  // Low-speed clock crossing and prescaler
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lsc_meta_q <= 1'b0;
      lsc_sync_q <= 1'b0;
      lsc_prev_q <= 1'b0;
    end
    else
    begin
      lsc_meta_q <= low_speed_clock;
      lsc_sync_q <= lsc_meta_q;
      lsc_prev_q <= lsc_sync_q;
    end
  end

  assign lsc_tick = lsc_sync_q && !lsc_prev_q;

  // Prescaler only advances while the clock gate supplies it, so a stopped
  // byte timer resumes mid-period rather than restarting
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_q <= '0;
    else if (lsc_tick && byte_timer_clock_gate_q)                      // [RULE6]
      pre_q <= pre_q + 7'h01;
  end

  // A divide-by-2^n tick is a low-speed edge on which the low n bits are all
  // ones; n of zero passes every edge
  function automatic logic div_tick(input logic [6:0] pre, input itp_pkg::itp_div_t sel);
    logic [6:0] m;
    m = 7'(8'h01 << sel) - 7'h01;
    div_tick = ((pre & m) == m);
  endfunction

  assign tick_ch0 = lsc_tick && byte_timer_clock_gate_q
                    && div_tick(pre_q, byte_timer_ch0_divsel_q);       // [RULE8] [RULE6]
  assign tick_ch1 = lsc_tick && byte_timer_clock_gate_q
                    && div_tick(pre_q, byte_timer_ch1_divsel_q);       // [RULE8] [RULE6]

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  // The long timer counts raw low-speed edges; a zero compare is left to
  // software and would simply interrupt on every edge
  itp_counter #(
    .W       (LONG_W)
  ) u_long (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (long_timer_run_q),                                       // [RULE2]
    .tick    (lsc_tick),
    .cmp     (long_timer_compare_q),                                   // [RULE3] [RULE4]
    .count_q (long_count),
    .match_q (long_match)
  );

  itp_counter #(
    .W       (BYTE_W)
  ) u_ch0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (byte_timer_ch0_go_q && !cascade_mode_select_q),          // [RULE7] [RULE5]
    .tick    (tick_ch0),
    .cmp     (byte_timer_compare_q[BYTE_W-1:0]),
    .count_q (ch0_count),
    .match_q (ch0_match)
  );

  itp_counter #(
    .W       (BYTE_W)
  ) u_ch1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (byte_timer_ch1_go_q && !cascade_mode_select_q),          // [RULE5]
    .tick    (tick_ch1),
    .cmp     (byte_timer_compare_q[2*BYTE_W-1:BYTE_W]),
    .count_q (ch1_count),
    .match_q (ch1_match)
  );

  // Joined channels run from channel zero's start bit and divider
  itp_counter #(
    .W       (2*BYTE_W)
  ) u_casc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (byte_timer_ch0_go_q && cascade_mode_select_q),           // [RULE5] [RULE7]
    .tick    (tick_ch0),
    .cmp     (byte_timer_compare_q),                                   // [RULE10]
    .count_q (casc_count),
    .match_q (casc_match)
  );

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  always_comb
  begin
    irq_set                    = '0;
    irq_set[`ITP_IRQ_LONG_BIT] = long_match;                           // [RULE1]
    irq_set[`ITP_IRQ_CH0_BIT]  = ch0_match || casc_match;              // [RULE10]
    irq_set[`ITP_IRQ_CH1_BIT]  = ch1_match;
  end

  assign irq_clr      = (rd_fire && rd_hit
                         && s_axi_araddr == ADDR_W'(`ITP_OFS_IRQ_STATUS))
                        ? '1 : '0;
  // A new event in the clearing cycle survives
  assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;           // [RULE1]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_q <= '0;
    else
      irq_status_q <= irq_status_d;                                    // [RULE1] [RULE9]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      long_timer_interval_irq <= 1'b0;
    else
      long_timer_interval_irq <= long_match;                           // [RULE3]
  end

  // Mask bit high withholds the request but not the status bit
  assign irq = |(irq_status_q & ~irq_mask_high_1_q);                   // [RULE9]

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_mask       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                          {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_comb
  begin
    unique case (aw_addr_q)
      ADDR_W'(`ITP_OFS_LONG_CTRL),
      ADDR_W'(`ITP_OFS_BYTE_CTRL),
      ADDR_W'(`ITP_OFS_BYTE_DIV),
      ADDR_W'(`ITP_OFS_BYTE_CMP),
      ADDR_W'(`ITP_OFS_IRQ_STATUS),
      ADDR_W'(`ITP_OFS_IRQ_MASK),
      ADDR_W'(`ITP_OFS_COUNT): wr_hit = 1'b1;
      default:                 wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ITP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `ITP_RESP_OKAY : `ITP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Byte strobes merge into the current register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign long_img = merge({16'h0000, long_timer_run_q, 3'h0, long_timer_compare_q}, w_data_q,
                          wr_mask);
  assign bcmp_img = merge({16'h0000, byte_timer_compare_q}, w_data_q, wr_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      long_timer_run_q     <= 1'b0;
      long_timer_compare_q <= `ITP_RST_LONG_CMP;
    end
    else if (wr_fire && aw_addr_q == ADDR_W'(`ITP_OFS_LONG_CTRL))
    begin
      long_timer_run_q     <= long_img[`ITP_LONG_RUN_BIT];             // [RULE2]
      long_timer_compare_q <= long_img[`ITP_LONG_CMP_MSB:0];           // [RULE3]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cascade_mode_select_q   <= 1'b0;
      byte_timer_clock_gate_q <= 1'b0;
      byte_timer_ch1_go_q     <= 1'b0;
      byte_timer_ch0_go_q     <= 1'b0;
    end
    else if (wr_fire && aw_addr_q == ADDR_W'(`ITP_OFS_BYTE_CTRL) && w_strb_q[0])
    begin
      cascade_mode_select_q   <= w_data_q[`ITP_CASCADE_BIT];           // [RULE5]
      byte_timer_clock_gate_q <= w_data_q[`ITP_GATE_BIT];              // [RULE6]
      byte_timer_ch1_go_q     <= w_data_q[`ITP_CH1_GO_BIT];
      byte_timer_ch0_go_q     <= w_data_q[`ITP_CH0_GO_BIT];            // [RULE7]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      byte_timer_ch1_divsel_q <= `ITP_RST_DIV;
      byte_timer_ch0_divsel_q <= `ITP_RST_DIV;
    end
    else if (wr_fire && aw_addr_q == ADDR_W'(`ITP_OFS_BYTE_DIV) && w_strb_q[0])
    begin
      byte_timer_ch1_divsel_q <= w_data_q[`ITP_CH1_DIV_LSB +: 3];
      byte_timer_ch0_divsel_q <= w_data_q[`ITP_CH0_DIV_LSB +: 3];      // [RULE8]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      byte_timer_compare_q <= `ITP_RST_BYTE_CMP;
    else if (wr_fire && aw_addr_q == ADDR_W'(`ITP_OFS_BYTE_CMP))
      byte_timer_compare_q <= bcmp_img[15:0];                          // [RULE10]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_high_1_q <= `ITP_RST_MASK;
    else if (wr_fire && aw_addr_q == ADDR_W'(`ITP_OFS_IRQ_MASK) && w_strb_q[0])
      irq_mask_high_1_q <= w_data_q[2:0];                              // [RULE9]
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(`ITP_OFS_LONG_CTRL):
      begin
        rd_word[`ITP_LONG_RUN_BIT]    = long_timer_run_q;
        rd_word[`ITP_LONG_CMP_MSB:0]  = long_timer_compare_q;
      end
      ADDR_W'(`ITP_OFS_BYTE_CTRL):
      begin
        rd_word[`ITP_CASCADE_BIT]     = cascade_mode_select_q;
        rd_word[`ITP_GATE_BIT]        = byte_timer_clock_gate_q;
        rd_word[`ITP_CH1_GO_BIT]      = byte_timer_ch1_go_q;
        rd_word[`ITP_CH0_GO_BIT]      = byte_timer_ch0_go_q;
      end
      ADDR_W'(`ITP_OFS_BYTE_DIV):
      begin
        rd_word[`ITP_CH1_DIV_LSB +: 3] = byte_timer_ch1_divsel_q;
        rd_word[`ITP_CH0_DIV_LSB +: 3] = byte_timer_ch0_divsel_q;
      end
      ADDR_W'(`ITP_OFS_BYTE_CMP):   rd_word[15:0] = byte_timer_compare_q;
      ADDR_W'(`ITP_OFS_IRQ_STATUS): rd_word[2:0]  = irq_status_q;      // [RULE1]
      ADDR_W'(`ITP_OFS_IRQ_MASK):   rd_word[2:0]  = irq_mask_high_1_q;
      ADDR_W'(`ITP_OFS_COUNT):
      begin
        rd_word[`ITP_COUNT_LONG_LSB +: LONG_W] = long_count;
        rd_word[15:0] = cascade_mode_select_q ? casc_count : {ch1_count, ch0_count};
      end
      default:                      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `ITP_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `ITP_RESP_OKAY : `ITP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// file: itp_timer_checker.sv
// Bus and interval-pulse assertions for the interval timer pair.
// Assumes a single aclk domain and the offsets of itp_consts.svh.
`timescale 1ns/1ns
`include "itp_consts.svh"
module itp_timer_checker #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Interrupts
  input wire logic              long_timer_interval_irq,
  input wire logic              irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Write sequences
  // ----------------------------------------
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[1:0] == 2'h0;
  endsequence
  sequence resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_write_resp_time: assert property (aw_w_taken |=> resp_late)
    else $error("write response late");
  a_write_resp_code: assert property (aw_w_taken |=> ##1 s_axi_bresp ==
    ($past(s_axi_awaddr, 2) > `ITP_OFS_COUNT ? `ITP_RESP_SLVERR : `ITP_RESP_OKAY))
    else $error("write response code wrong");
  a_read_resp_code: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'h0
    |=> s_axi_rvalid && s_axi_rresp ==
    ($past(s_axi_araddr) > `ITP_OFS_COUNT ? `ITP_RESP_SLVERR : `ITP_RESP_OKAY))
    else $error("read answer wrong");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // Ticks come at most every four cycles and compare is never zero
  a_pulse_spacing: assert property (long_timer_interval_irq |=> !long_timer_interval_irq [*7])
    else $error("interval pulses too close");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy after reset");
endmodule

bind itp_timer itp_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .long_timer_interval_irq(long_timer_interval_irq), .irq(irq));

// file: itp_timer_tb.sv
// Self-checking bench for the interval timer pair.
// Assumes the register map of itp_consts.svh; drives the slow clock itself.
`timescale 1ns/1ns
`include "itp_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h seen %0h", n, e, g); end end
module itp_timer_tb;
  logic        aclk, aresetn, lsc, pulse, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, cexp;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, wexp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [33:0] rq[$], rexp;
  logic [1:0]  wq[$];
  int          n_mismatch, cmp_count, seed, npulse, cmp, d, e;

  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  itp_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .low_speed_clock(lsc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .long_timer_interval_irq(pulse), .irq(irq));

  // ----------------------------------------
  // Result watcher: oldest note against each answer
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (pulse === 1'b1) npulse++;
    if (rvalid === 1'b1 && rready)
    begin
      rexp = rq.pop_front();
      `CHK("read", rexp, {rresp, rdata})
    end
    if (bvalid === 1'b1 && bready)
    begin
      wexp = wq.pop_front();
      `CHK("bresp", wexp, bresp)
    end
  end

  task automatic rst();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    wq.push_back(r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    rq.push_back({r, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Slow clock runs at an eighth of aclk, and only while asked to
  task automatic edges(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      lsc <= 1'b1;
      repeat (4) @(posedge aclk);
      lsc <= 1'b0;
    end
    repeat (8) @(posedge aclk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    {aresetn, lsc, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    seed = 25;
    rst();
    rd(`ITP_OFS_LONG_CTRL, 32'h0000_0FFF, `ITP_RESP_OKAY);
    rd(`ITP_OFS_BYTE_CMP, 32'h0000_FFFF, `ITP_RESP_OKAY);
    rd(`ITP_OFS_IRQ_MASK, 32'h0000_0007, `ITP_RESP_OKAY);
    rd(`ITP_OFS_IRQ_STATUS, 32'h0, `ITP_RESP_OKAY);
    rd(8'h1C, 32'h0, `ITP_RESP_SLVERR);
    wr(8'h1C, 32'h1, `ITP_RESP_SLVERR);
    wstrb <= 4'h2;
    wr(`ITP_OFS_BYTE_CMP, 32'h0000_AB55, `ITP_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`ITP_OFS_BYTE_CMP, 32'h0000_ABFF, `ITP_RESP_OKAY);
    $display("test reset_map done");
    cmp = 1 + ($random(seed) & 7);
    wr(`ITP_OFS_IRQ_MASK, 32'h6, `ITP_RESP_OKAY);
    npulse = 0;
    wr(`ITP_OFS_LONG_CTRL, 32'h8000 | cmp, `ITP_RESP_OKAY);
    edges(3 * (cmp + 1));
    `CHK("pulses", 3, npulse)
    `CHK("irq", 1'b1, irq)
    rd(`ITP_OFS_IRQ_STATUS, 32'h1, `ITP_RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    edges(cmp);
    rd(`ITP_OFS_COUNT, cmp << 16, `ITP_RESP_OKAY);
    wr(`ITP_OFS_IRQ_MASK, 32'h7, `ITP_RESP_OKAY);
    edges(1);
    `CHK("irq", 1'b0, irq)
    rd(`ITP_OFS_IRQ_STATUS, 32'h1, `ITP_RESP_OKAY);
    wr(`ITP_OFS_LONG_CTRL, cmp, `ITP_RESP_OKAY);
    rd(`ITP_OFS_COUNT, 32'h0, `ITP_RESP_OKAY);
    edges(cmp + 1);
    `CHK("pulses", 4, npulse)
    rd(`ITP_OFS_IRQ_STATUS, 32'h0, `ITP_RESP_OKAY);
    $display("test long_timer done");
    for (d = 0; d < 8; d++)
    begin
      rst();
      e = 1 + ($random(seed) & 255);
      cexp = (((e >> (7 - d)) & 255) << 8) | ((e >> d) & 255);
      wr(`ITP_OFS_BYTE_DIV, d | ((7 - d) << 4), `ITP_RESP_OKAY);
      wr(`ITP_OFS_BYTE_CTRL, 32'h13, `ITP_RESP_OKAY);
      edges(e);
      rd(`ITP_OFS_COUNT, cexp, `ITP_RESP_OKAY);
    end
    wr(`ITP_OFS_BYTE_CTRL, 32'h03, `ITP_RESP_OKAY);
    edges(4);
    rd(`ITP_OFS_COUNT, cexp, `ITP_RESP_OKAY);
    wr(`ITP_OFS_BYTE_CTRL, 32'h10, `ITP_RESP_OKAY);
    rd(`ITP_OFS_COUNT, 32'h0, `ITP_RESP_OKAY);
    $display("test byte_timer done");
    rst();
    wr(`ITP_OFS_IRQ_MASK, 32'h0, `ITP_RESP_OKAY);
    wr(`ITP_OFS_BYTE_CMP, 32'h0102, `ITP_RESP_OKAY);
    wr(`ITP_OFS_BYTE_CTRL, 32'h91, `ITP_RESP_OKAY);
    edges(257);
    rd(`ITP_OFS_COUNT, 32'h0101, `ITP_RESP_OKAY);
    edges(2);
    rd(`ITP_OFS_COUNT, 32'h0, `ITP_RESP_OKAY);
    `CHK("irq", 1'b1, irq)
    rd(`ITP_OFS_IRQ_STATUS, 32'h2, `ITP_RESP_OKAY);
    $display("test cascade done");
    stop_test();
  end
endmodule
